/* File: rtl/mtx_pkg.sv */
// Purpose: Shared constants and types for the mask-test / xor / wait execution unit
// Assumes: 8-bit datapath, flags C Z S V D H
// Notes: Opcode values and cycle counts are defined here; the bench and checks also use literals
package mtx_pkg;

  // ---------------------------------------------------------------
  // Opcode ranges
  // ---------------------------------------------------------------
  localparam logic [7:0] MTX_OP_TST_CMPL_LO = 8'h62;
  localparam logic [7:0] MTX_OP_TST_CMPL_HI = 8'h66;
  localparam logic [7:0] MTX_OP_TST_MASK_LO = 8'h72;
  localparam logic [7:0] MTX_OP_TST_MASK_HI = 8'h76;
  localparam logic [7:0] MTX_OP_XOR_LO = 8'hb2;
  localparam logic [7:0] MTX_OP_XOR_HI = 8'hb6;
  localparam logic [7:0] MTX_OP_WAIT = 8'h3f;

  // Low nibble of each form
  localparam logic [3:0] MTX_FORM_RR = 4'h2;
  localparam logic [3:0] MTX_FORM_RIR = 4'h3;
  localparam logic [3:0] MTX_FORM_REGREG = 4'h4;
  localparam logic [3:0] MTX_FORM_IND = 4'h5;
  localparam logic [3:0] MTX_FORM_IMM = 4'h6;

  // ---------------------------------------------------------------
  // Timing and field positions
  // ---------------------------------------------------------------
  localparam logic [3:0] MTX_CYC_SHORT = 4'h4;
  localparam logic [3:0] MTX_CYC_LONG = 4'h6;
  localparam logic [3:0] MTX_CYC_WAIT_UNIT = 4'h4;
  localparam int MTX_SIGN_BIT = 7;
  localparam logic [5:0] MTX_FLAGS_RESET = 6'h00;

  // Flag vector, bit order C Z S V D H
  typedef struct packed {
    logic c;
    logic z;
    logic s;
    logic v;
    logic d;
    logic h;
  } mtx_flags_t;

  // Decoded instruction as offered by the decoder
  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] byte2;
    logic [7:0] byte3;
  } mtx_instr_t;

  // Register file write request
  typedef struct packed {
    logic we;
    logic [7:0] addr;
    logic [7:0] data;
  } mtx_wr_t;

  // Operation class
  typedef enum logic [1:0] {
    MTX_CLS_NONE,
    MTX_CLS_TST_CMPL,
    MTX_CLS_TST_MASK,
    MTX_CLS_XOR
  } mtx_cls_t;

endpackage

/* File: rtl/mtx_logic_unit.sv */
// Purpose: Combinational-to-register result stage for the logic operations
// Assumes: Operands valid in the cycle that go is high
// Notes: Result and flags come out of registers one cycle after go
`timescale 1ns/1ns
`default_nettype none
module mtx_logic_unit (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Request
  input wire logic go,
  input wire mtx_pkg::mtx_cls_t cls,
  input wire logic [7:0] dst_val,
  input wire logic [7:0] src_val,
  input wire mtx_pkg::mtx_flags_t flags_in,
  // Answer
  output logic [7:0] result_reg,
  output var mtx_pkg::mtx_flags_t flags_reg
);
  import mtx_pkg::*;

  // ---------------------------------------------------------------
  // Result computation
  // ---------------------------------------------------------------
  logic [7:0] res_next; // Raw result of the selected operation

  // Pick the operation
  always_comb begin
    case (cls)
      // (RL1) complement then mask
      MTX_CLS_TST_CMPL: res_next = (~dst_val) & src_val;
      // (RL3) plain mask
      MTX_CLS_TST_MASK: res_next = dst_val & src_val;
      // (RL5) bitwise difference
      MTX_CLS_XOR: res_next = dst_val ^ src_val;
      default: res_next = 8'h00;
    endcase
  end

  // Register result
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      result_reg <= 8'h00;
    end else if (go) begin
      result_reg <= res_next;
    end
  end

  // (RL2) (RL4) (RL6) Z and S from result, V cleared, C D H kept
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      flags_reg <= mtx_flags_t'(MTX_FLAGS_RESET);
    end else if (go) begin
      flags_reg.c <= flags_in.c;
      flags_reg.z <= (res_next == 8'h00);
      flags_reg.s <= res_next[MTX_SIGN_BIT];
      flags_reg.v <= 1'b0;
      flags_reg.d <= flags_in.d;
      flags_reg.h <= flags_in.h;
    end
  end

endmodule
`default_nettype wire

/* File: rtl/mtx_exec.sv */
// Purpose: Execution of mask tests, exclusive-OR and wait-for-interrupt
// Assumes: Decoder supplies opcode bytes and fetched operand values
// Notes: One request at a time; busy stays high until done
//
// Overview of operation
// (RL1) Complement destination, AND mask, flags only
// (RL2) Complement test: Z, S, V clear, 62-66
// (RL3) Mask test ANDs, flags only, no writes
// (RL4) Mask test flags; 4 or 6 cycles
// (RL5) XOR result written to destination
// (RL6) XOR flags Z S, V clear, B2-B6
// (RL7) Wait halts until interrupt, 4n cycles
// (RL8) Grant DMA requests while waiting
// (RL9) Source byte2, destination byte3; immediate reversed
`timescale 1ns/1ns
`default_nettype none
module mtx_exec (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Instruction from decoder
  input wire logic start,
  input wire mtx_pkg::mtx_instr_t instr,
  input wire logic [7:0] dst_val,
  input wire logic [7:0] src_val,
  input wire mtx_pkg::mtx_flags_t flags_in,
  // System events
  input wire logic irq,
  input wire logic dma_req,
  // Results
  output logic busy_reg,
  output logic done_reg,
  output logic flags_we_reg,
  output var mtx_pkg::mtx_flags_t flags_out,
  output var mtx_pkg::mtx_wr_t wr_reg,
  output logic [7:0] src_addr_reg,
  output logic [7:0] dst_addr_reg,
  output logic halted_reg,
  output logic dma_grant_reg
);
  import mtx_pkg::*;

  // ---------------------------------------------------------------
  // Decode helpers
  // ---------------------------------------------------------------
  // Class of an opcode, shared by decode and checks
  function automatic mtx_cls_t cls_of(input logic [7:0] op);
    if (op >= MTX_OP_TST_CMPL_LO && op <= MTX_OP_TST_CMPL_HI) begin
      return MTX_CLS_TST_CMPL;
    end else if (op >= MTX_OP_TST_MASK_LO && op <= MTX_OP_TST_MASK_HI) begin
      return MTX_CLS_TST_MASK;
    end else if (op >= MTX_OP_XOR_LO && op <= MTX_OP_XOR_HI) begin
      return MTX_CLS_XOR;
    end
    return MTX_CLS_NONE;
  endfunction

  // Cycle count of a form
  function automatic logic [3:0] cyc_of(input logic [7:0] op);
    if (op[3:0] == MTX_FORM_RR) begin
      return MTX_CYC_SHORT;
    end
    return MTX_CYC_LONG;
  endfunction

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_RUN,
    ST_WAIT
  } mtx_state_t;

  mtx_state_t state_reg; // Sequencer state
  mtx_cls_t cls_in; // Class of incoming opcode
  mtx_cls_t cls_reg; // Class of current instruction
  logic [3:0] cnt_reg; // Cycles left in current step
  logic [7:0] daddr_reg; // Destination for the write
  logic go; // Launch the logic unit
  logic [7:0] res_w; // Result from logic unit
  logic irq_seen_reg; // Interrupt came during current 4-cycle slot

  assign cls_in = cls_of(instr.opcode);
  assign go = start && (state_reg == ST_IDLE) && (cls_in != MTX_CLS_NONE);

  // ---------------------------------------------------------------
  // Logic unit
  // ---------------------------------------------------------------
  mtx_logic_unit u_logic (
    .sys_clk(sys_clk),
    .rst(rst),
    .go(go),
    .cls(cls_in),
    .dst_val(dst_val),
    .src_val(src_val),
    .flags_in(flags_in),
    .result_reg(res_w),
    .flags_reg(flags_out)
  );

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  // Counts out the documented cycles, then pulses done
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 4'h0;
      cls_reg <= MTX_CLS_NONE;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (go) begin
            // (RL4) two-byte RR form 4 cycles, all others including two-byte RIR 6
            state_reg <= ST_RUN;
            cnt_reg <= cyc_of(instr.opcode) - 4'h1;
            cls_reg <= cls_in;
          end else if (start && instr.opcode == MTX_OP_WAIT) begin
            // (RL7) wait proceeds in 4-cycle slots
            state_reg <= ST_WAIT;
            cnt_reg <= MTX_CYC_WAIT_UNIT - 4'h1;
          end
        end
        ST_RUN: begin
          if (cnt_reg == 4'h1) begin
            state_reg <= ST_IDLE;
          end
          cnt_reg <= cnt_reg - 4'h1;
        end
        ST_WAIT: begin
          // (RL7) release only at a slot end after an interrupt
          if (cnt_reg == 4'h1) begin
            if (irq || irq_seen_reg) begin
              state_reg <= ST_IDLE;
            end
          end
          cnt_reg <= (cnt_reg == 4'h1) ? MTX_CYC_WAIT_UNIT : cnt_reg - 4'h1;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Interrupt memory within a wait slot so a short pulse is not lost
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_seen_reg <= 1'b0;
    end else if (state_reg != ST_WAIT || cnt_reg == 4'h1) begin
      irq_seen_reg <= 1'b0;
    end else if (irq) begin
      irq_seen_reg <= 1'b1;
    end
  end

  // Status outputs
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      halted_reg <= 1'b0;
    end else begin
      busy_reg <= (state_reg == ST_IDLE) ? (go || (start && instr.opcode == MTX_OP_WAIT))
                                         : !(cnt_reg == 4'h1 &&
                                             (state_reg == ST_RUN || irq || irq_seen_reg));
      done_reg <= (cnt_reg == 4'h1) &&
                  (state_reg == ST_RUN || (state_reg == ST_WAIT && (irq || irq_seen_reg)));
      halted_reg <= (state_reg == ST_IDLE) ? (start && instr.opcode == MTX_OP_WAIT && !go)
                                           : (state_reg == ST_WAIT) &&
                                             !(cnt_reg == 4'h1 && (irq || irq_seen_reg));
    end
  end

  // (RL8) DMA grant follows request while halted
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      dma_grant_reg <= 1'b0;
    end else begin
      dma_grant_reg <= dma_req && (state_reg == ST_WAIT);
    end
  end

  // (RL9) operand addresses by form
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      src_addr_reg <= 8'h00;
      dst_addr_reg <= 8'h00;
      daddr_reg <= 8'h00;
    end else if (go) begin
      if (instr.opcode[3:0] == MTX_FORM_IMM) begin
        dst_addr_reg <= instr.byte2;
        src_addr_reg <= instr.byte3;
        daddr_reg <= instr.byte2;
      end else if (instr.opcode[3:0] == MTX_FORM_REGREG ||
                   instr.opcode[3:0] == MTX_FORM_IND) begin
        src_addr_reg <= instr.byte2;
        dst_addr_reg <= instr.byte3;
        daddr_reg <= instr.byte3;
      end else begin
        // Two-byte forms: destination high nibble, source low nibble
        dst_addr_reg <= {4'h0, instr.byte2[7:4]};
        src_addr_reg <= {4'h0, instr.byte2[3:0]};
        daddr_reg <= {4'h0, instr.byte2[7:4]};
      end
    end
  end

  // Flag write strobe at completion of a logic operation
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      flags_we_reg <= 1'b0;
    end else begin
      // (RL7) wait never touches flags
      flags_we_reg <= (state_reg == ST_RUN) && (cnt_reg == 4'h1);
    end
  end

  // (RL5) destination write only for XOR; (RL1) (RL3) tests write nothing
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wr_reg <= '0;
    end else begin
      wr_reg.we <= (state_reg == ST_RUN) && (cnt_reg == 4'h1) && (cls_reg == MTX_CLS_XOR);
      wr_reg.addr <= daddr_reg;
      wr_reg.data <= res_w;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_tests_no_write: assert property (@(posedge sys_clk) disable iff (rst) // (RL3)
    wr_reg.we |-> $past(cls_reg) == MTX_CLS_XOR)
    else $error("destination written by a test operation");

  a_short_form_len: assert property (@(posedge sys_clk) disable iff (rst) // (RL4)
    (go && instr.opcode[3:0] == MTX_FORM_RR) |=> busy_reg ##3 done_reg)
    else $error("two-byte form not done in 4 cycles");

  a_long_form_len: assert property (@(posedge sys_clk) disable iff (rst) // (RL4)
    (go && instr.opcode[3:0] != MTX_FORM_RR) |=> !done_reg [*5] ##1 done_reg)
    else $error("long form not done in 6 cycles");

  a_v_cleared: assert property (@(posedge sys_clk) disable iff (rst) // (RL2)
    flags_we_reg |-> !flags_out.v)
    else $error("overflow flag not cleared");

  a_zero_flag: assert property (@(posedge sys_clk) disable iff (rst) // (RL6)
    wr_reg.we |-> (flags_out.z == (wr_reg.data == 8'h00)) && flags_out.s == wr_reg.data[7])
    else $error("Z or S does not match written result");

  a_cmpl_result: assert property (@(posedge sys_clk) disable iff (rst) // (RL1)
    (go && cls_in == MTX_CLS_TST_CMPL) |=>
      flags_out.z == ((~$past(dst_val) & $past(src_val)) == 8'h00))
    else $error("complement test Z wrong");

  a_dma_in_wait: assert property (@(posedge sys_clk) disable iff (rst) // (RL8)
    (state_reg == ST_WAIT && dma_req) |=> dma_grant_reg)
    else $error("DMA not granted while waiting");

  a_wait_no_flags: assert property (@(posedge sys_clk) disable iff (rst) // (RL7)
    (state_reg == ST_WAIT) |-> !flags_we_reg)
    else $error("flags written during wait");

  a_imm_dst_first: assert property (@(posedge sys_clk) disable iff (rst) // (RL9)
    (go && instr.opcode[3:0] == MTX_FORM_IMM) |=> dst_addr_reg == $past(instr.byte2))
    else $error("immediate form destination not from byte2");

endmodule
`default_nettype wire

/* File: tb/mtx_regfile_model.sv */
// Purpose: Far-side model of the register file and flag register
// Assumes: Writes and flag loads arrive as one-cycle strobes
// Notes: Read port is combinational so the bench can peek after a write
`timescale 1ns/1ns
`default_nettype none
module mtx_regfile_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Strobes from the unit
  input wire mtx_pkg::mtx_wr_t wr,
  input wire logic flags_we,
  input wire mtx_pkg::mtx_flags_t flags_new,
  // Peek side
  input wire logic [7:0] rd_addr,
  output logic [7:0] rd_data,
  output var mtx_pkg::mtx_flags_t flags_q,
  output var logic [7:0] wr_count
);
  import mtx_pkg::*;
  // --------------------------------------------
  // Storage
  // --------------------------------------------
  logic [7:0] mem [0:255]; // Register file image, left unreset like real RAM
  assign rd_data = mem[rd_addr];
  // Byte write on the strobe; the count lets the bench spot stray writes
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wr_count <= 8'h00;
    end else if (wr.we) begin
      mem[wr.addr] <= wr.data;
      wr_count <= wr_count + 8'h01;
    end
  end
  // Flag register loads only when strobed
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      flags_q <= mtx_flags_t'(MTX_FLAGS_RESET);
    end else if (flags_we) begin
      flags_q <= flags_new;
    end
  end
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
// Purpose: Self-checking bench for the mask-test / xor / wait unit
// Assumes: Operand values are resolved by the bench in the start cycle
// Notes: Inputs change on the falling edge only
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_fail++; $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module tb_top;
  import mtx_pkg::*;
  // --------------------------------------------
  // Signals
  // --------------------------------------------
  logic sys_clk, rst, start, irq, dma_req, busy_reg, done_reg, flags_we_reg;
  logic halted_reg, dma_grant_reg;
  mtx_instr_t instr;
  mtx_flags_t flags_in, flags_out, flags_q;
  mtx_wr_t wr_reg;
  logic [7:0] dst_val, src_val, src_addr_reg, dst_addr_reg, rd_addr, rd_data, wr_count;
  int n_fail, samples_checked;
  mtx_exec mtx_exec_inst (.sys_clk(sys_clk), .rst(rst), .start(start), .instr(instr),
    .dst_val(dst_val), .src_val(src_val), .flags_in(flags_in), .irq(irq),
    .dma_req(dma_req), .busy_reg(busy_reg), .done_reg(done_reg),
    .flags_we_reg(flags_we_reg), .flags_out(flags_out), .wr_reg(wr_reg),
    .src_addr_reg(src_addr_reg), .dst_addr_reg(dst_addr_reg),
    .halted_reg(halted_reg), .dma_grant_reg(dma_grant_reg));
  mtx_regfile_model mtx_regfile_model_inst (.sys_clk(sys_clk), .rst(rst), .wr(wr_reg),
    .flags_we(flags_we_reg), .flags_new(flags_out), .rd_addr(rd_addr),
    .rd_data(rd_data), .flags_q(flags_q), .wr_count(wr_count));
  // --------------------------------------------
  // Shared tasks
  // --------------------------------------------
  // Offer one instruction; start is left high, the caller lowers it
  task automatic issue(input logic [7:0] op, b2, b3, dv, sv, input mtx_flags_t fl);
    @(negedge sys_clk);
    start = 1'b1;
    instr = '{op, b2, b3};
    dst_val = dv;
    src_val = sv;
    flags_in = fl;
    @(negedge sys_clk);
  endtask
  // n counts edges since the taking edge; bounded so a hang cannot stall
  task automatic wait_done(inout int n);
    while (done_reg !== 1'b1 && n < 200) begin
      @(negedge sys_clk);
      n++;
    end
  endtask
  // --------------------------------------------
  // Scenarios
  // --------------------------------------------
  // All five forms of one logic family, with a refused start while busy
  task automatic test_logic(input logic [3:0] fam);
    logic [7:0] dv, sv, res, ed;
    logic [7:0] wc;
    mtx_flags_t fl, ef;
    int n;
    fl = 6'b101110;
    for (int f = 2; f <= 6; f++) begin
      dv = (f < 4) ? 8'hc7 : 8'h2b;
      sv = (f == 3 || f == 5) ? 8'h23 : ((f == 6) ? 8'h54 : 8'h02);
      res = (fam == 4'hb) ? (dv ^ sv) : ((fam == 4'h6) ? (~dv & sv) : (dv & sv));
      ef = '{fl.c, res == 8'h00, res[7], 1'b0, fl.d, fl.h};
      ed = (f < 4) ? 8'h05 : ((f < 6) ? 8'h9c : 8'h5a);
      wc = wr_count;
      issue({fam, f[3:0]}, 8'h5a, 8'h9c, dv, sv, fl);
      instr = '{8'hb6, 8'h11, 8'h22};
      dst_val = 8'hff;
      @(negedge sys_clk);
      `CHK("busy_run", 1'b1, busy_reg)
      start = 1'b0;
      n = 2;
      wait_done(n);
      `CHK("cycles", (f == 2) ? 4 : 6, n)
      `CHK("busy_end", 1'b0, busy_reg)
      `CHK("flags_out", ef, flags_out)
      `CHK("flags_we", 1'b1, flags_we_reg)
      `CHK("wr_we", fam == 4'hb, wr_reg.we)
      `CHK("dst_addr", ed, dst_addr_reg)
      if (f == 4 || f == 5) `CHK("src_addr", 8'h5a, src_addr_reg)
      if (f == 6) `CHK("src_imm", 8'h9c, src_addr_reg)
      if (f < 4) `CHK("src_nib", 4'ha, src_addr_reg[3:0])
      @(negedge sys_clk);
      `CHK("flag_reg", ef, flags_q)
      if (fam == 4'hb) begin
        rd_addr = wr_reg.addr;
        #1;
        `CHK("xor_res", res, rd_data)
        `CHK("xor_addr", ed, wr_reg.addr)
      end else begin
        `CHK("no_write", wc, wr_count)
      end
    end
  endtask
  // Wait released at a four-cycle slot end; DMA granted while halted
  task automatic test_wait(input int irq_at, input int exp_n);
    mtx_flags_t f0;
    logic [7:0] wc;
    int n;
    f0 = flags_q;
    wc = wr_count;
    issue(MTX_OP_WAIT, 8'h00, 8'h00, 8'h00, 8'h00, f0);
    start = 1'b0;
    dma_req = 1'b1;
    n = 1;
    while (n < irq_at) begin
      @(negedge sys_clk);
      n++;
      if (n == 3) begin
        `CHK("halted", 1'b1, halted_reg)
        `CHK("dma_grant", 1'b1, dma_grant_reg)
      end
    end
    irq = 1'b1;
    @(negedge sys_clk);
    n++;
    irq = 1'b0;
    wait_done(n);
    `CHK("wait_cycles", exp_n, n)
    `CHK("halt_end", 1'b0, halted_reg)
    repeat (2) @(negedge sys_clk);
    `CHK("grant_idle", 1'b0, dma_grant_reg)
    `CHK("wait_flags", f0, flags_q)
    `CHK("wait_nowr", wc, wr_count)
    dma_req = 1'b0;
  endtask
  // --------------------------------------------
  // Verdict, clock and sequence
  // --------------------------------------------
  task automatic final_report();
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  initial begin
    rst = 1'b1;
    start = 1'b0;
    instr = '0;
    dst_val = 8'h00;
    src_val = 8'h00;
    flags_in = '0;
    irq = 1'b0;
    dma_req = 1'b0;
    rd_addr = 8'h00;
    n_fail = 0;
    samples_checked = 0;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 1'b0;
    test_logic(4'h6);
    test_logic(4'h7);
    test_logic(4'hb);
    test_wait(2, 4);
    test_wait(5, 8);
    final_report();
  end
  // Whole run is well under 200 cycles; this limit catches a hang
  initial begin
    #20000;
    n_fail++;
    final_report();
  end
endmodule
`default_nettype wire
